// ===== rtl/ieg_top.sv
// Interrupt enable gating: enable registers, register port and request gating
// Register map
//   0xa8 primary enables
//     bit 7 global gate over every interrupt output
//     bit 6 reserved, writes ignored, reads zero
//     bit 5 Timer2 request enable
//     bit 4 first serial port request enable
//     bit 3 Timer1 request enable
//     bit 2 pin B interrupt and wake enable
//     bit 1 Timer0 request enable
//     bit 0 pin A interrupt and wake enable
//   0xa9 secondary enables
//     bit 7 pulse group enable, other bits read zero
//   0xc0 pulse channel enables
//     bit n enables channel n, upper bits read zero
//   Any other address: writes dropped, reads zero
//   All enables clear to zero on reset
//
// Register port
//   One-cycle write strobe with address and data
//   A write lands at the edge that samples its strobe
//   One-cycle read strobe with address
//   Read data stand only in the cycle after the strobe
//   Read data are zero otherwise, so no valid flag is needed
//   The port never stalls; strobes may run back to back
//   Both strobes at once is not a legal request
//
// Request path
//   Requests are sampled with the enables of the same edge
//   Gated outputs follow one cycle later, as levels
//   An enable written at one edge acts from the next cycle
//   Pulse channels need channel, group and global enables
//   The pulse summary is the OR of the gated channels
//
// Wake-up
//   Wake outputs follow a pin and its own enable only
//   The global gate is left out so a halted core can wake
//   Software that wants no wake must clear the pin enable
//
// Clock enable
//   Low freezes registers, read data and gated outputs
//   A strobe seen while frozen is dropped, not queued
//   Requests seen while frozen are not remembered either
//
// Reset
//   Asynchronous, active low, clears all registers
//   Read data and gated outputs are zero while it is low
//   The first strobe may follow in the first cycle after release
//
// Gate link
//   Enables and raw requests travel to the gate in one interface
//   The gate returns its registered outputs in the same bundle
//
// Limitations
//   Inputs are taken as synchronous to the clock
//   Asynchronous pins need synchronisers outside this block
//   No priority or vectoring here; the core sorts requests out
//   The block holds no pending flags; sources keep their own
//   The output stage costs one cycle of latency but keeps
//   the lines to the core free of decode glitches
module ieg_top (
    // Clock, reset and freeze
    input  wire logic                                 i_mclk,
    input  wire logic                                 i_rstn,
    input  wire logic                                 i_ce,
    // Register port
    input  wire logic [ieg_pkg::ADDR_W-1:0]           i_addr,
    input  wire logic [ieg_pkg::DATA_W-1:0]           i_wdata,
    input  wire logic                                 i_wr,
    input  wire logic                                 i_rd,
    output logic      [ieg_pkg::DATA_W-1:0]           o_rdata,
    // Raw requests from the sources
    input  wire logic                                 i_timer0_req,
    input  wire logic                                 i_timer1_req,
    input  wire logic                                 i_timer2_req,
    input  wire logic                                 i_uart1_req,
    input  wire logic                                 i_ext_irq_pin_a,
    input  wire logic                                 i_ext_irq_pin_b,
    input  wire logic [ieg_pkg::PULSE_CH_NUM-1:0]     i_pulse_ch_req,
    // Gated requests to the core interrupt logic
    output logic                                      o_timer0_irq,
    output logic                                      o_timer1_irq,
    output logic                                      o_timer2_irq,
    output logic                                      o_uart1_irq,
    output logic                                      o_ext_pin_a_irq,
    output logic                                      o_ext_pin_b_irq,
    output logic      [ieg_pkg::PULSE_CH_NUM-1:0]     o_pulse_ch_irq,
    output logic                                      o_pulse_irq,
    // Wake-up requests to the power control
    output logic                                      o_wake_pin_a,
    output logic                                      o_wake_pin_b
);
    ieg_pkg::ieg_regs_type st_reg;   // All register state
    ieg_pkg::ieg_regs_type st_next;  // Next value
    ieg_gate_if            gif ();   // Link to the gate

    // Reserved bits are masked on write rather than on read,
    // so the stored value and the read value never differ
    // Masked write keeps reserved bits at zero
    function automatic logic [7:0] wr_field(input logic [7:0] old, input logic [7:0] wd,
                                            input logic [7:0] mask);
        wr_field = (old & ~mask) | (wd & mask);
    endfunction

    // Next-state logic of the whole register file
    // Write and read never arrive together, so no priority is needed
    // Register writes and registered read data
    always_comb begin
        st_next = st_reg;
        // Writes: values stay until rewritten or reset
        if (i_wr) begin
            unique case (i_addr)
                ieg_pkg::PRIMARY_IRQ_ENABLE_OFS: begin
                    st_next.primary = wr_field(st_reg.primary, i_wdata,
                                               ieg_pkg::PRIMARY_WR_MASK);
                end
                ieg_pkg::SECONDARY_IRQ_ENABLE_OFS: begin
                    st_next.secondary = wr_field(st_reg.secondary, i_wdata,
                                                 ieg_pkg::SECONDARY_WR_MASK);
                end
                ieg_pkg::PULSE_CH_IRQ_ENABLE_OFS: begin
                    st_next.pulse_ch = wr_field(st_reg.pulse_ch, i_wdata,
                                                ieg_pkg::PULSE_CH_WR_MASK);
                end
                // Unmapped writes are dropped
                // Silent drop keeps the port free of error paths
                default: begin
                end
            endcase
        end
        // Read data valid only in the cycle after the strobe
        // Zero by default so a stale value never lingers
        st_next.rdata = ieg_pkg::RDATA_RST;
        if (i_rd) begin
            unique case (i_addr)
                ieg_pkg::PRIMARY_IRQ_ENABLE_OFS: begin
                    st_next.rdata = st_reg.primary;
                end
                ieg_pkg::SECONDARY_IRQ_ENABLE_OFS: begin
                    st_next.rdata = st_reg.secondary;
                end
                ieg_pkg::PULSE_CH_IRQ_ENABLE_OFS: begin
                    st_next.rdata = st_reg.pulse_ch;
                end
                // Unmapped reads return zero
                // Same value as a reserved bit, one rule everywhere
                default: begin
                    st_next.rdata = ieg_pkg::RDATA_RST;
                end
            endcase
        end
    end

    // State register, frozen while the clock enable is low
    // Reset clears every enable, so nothing passes until software acts
    // Fields reset one by one to name each reset value
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg.primary   <= ieg_pkg::PRIMARY_RST;
            st_reg.secondary <= ieg_pkg::SECONDARY_RST;
            st_reg.pulse_ch  <= ieg_pkg::PULSE_CH_RST;
            st_reg.rdata     <= ieg_pkg::RDATA_RST;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    // Enable fields out to the gate
    // Field positions come from the package, one name each
    // Enables reach the gate straight from the flops
    // Reserved bits are never routed anywhere
    assign gif.global_irq_gate      = st_reg.primary[ieg_pkg::GLOBAL_IRQ_GATE_BIT];
    assign gif.timer2_irq_en        = st_reg.primary[ieg_pkg::TIMER2_IRQ_EN_BIT];
    assign gif.uart1_irq_en         = st_reg.primary[ieg_pkg::UART1_IRQ_EN_BIT];
    assign gif.timer1_irq_en        = st_reg.primary[ieg_pkg::TIMER1_IRQ_EN_BIT];
    assign gif.ext_pin1_irq_wake_en = st_reg.primary[ieg_pkg::EXT_PIN1_IRQ_WAKE_EN_BIT];
    assign gif.timer0_irq_en        = st_reg.primary[ieg_pkg::TIMER0_IRQ_EN_BIT];
    assign gif.ext_pin0_irq_wake_en = st_reg.primary[ieg_pkg::EXT_PIN0_IRQ_WAKE_EN_BIT];
    assign gif.pulse_group_irq_en   = st_reg.secondary[ieg_pkg::PULSE_GROUP_IRQ_EN_BIT];
    assign gif.pulse_ch_irq_en      = st_reg.pulse_ch[ieg_pkg::PULSE_CH_NUM-1:0];

    // Raw requests to the gate
    // Passed through untouched; the gate registers them once
    assign gif.timer0_req    = i_timer0_req;
    assign gif.timer1_req    = i_timer1_req;
    assign gif.timer2_req    = i_timer2_req;
    assign gif.uart1_req     = i_uart1_req;
    assign gif.ext_irq_pin_a = i_ext_irq_pin_a;
    assign gif.ext_irq_pin_b = i_ext_irq_pin_b;
    assign gif.pulse_ch_req  = i_pulse_ch_req;

    // Gating logic
    // One flop stage for every gated line
    ieg_gate i_ieg_gate (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .i_ce   (i_ce),
        .gif    (gif)
    );

    // Outputs, all from flip-flops
    // Read data from the register file, requests from the gate
    // Every output comes from a flop, never from decode
    assign o_rdata         = st_reg.rdata;
    assign o_timer0_irq    = gif.gated.timer0_irq;
    assign o_timer1_irq    = gif.gated.timer1_irq;
    assign o_timer2_irq    = gif.gated.timer2_irq;
    assign o_uart1_irq     = gif.gated.uart1_irq;
    assign o_ext_pin_a_irq = gif.gated.ext_pin_a_irq;
    assign o_ext_pin_b_irq = gif.gated.ext_pin_b_irq;
    assign o_pulse_ch_irq  = gif.gated.pulse_ch_irq;
    assign o_pulse_irq     = gif.gated.pulse_irq;
    assign o_wake_pin_a    = gif.gated.wake_pin_a;
    assign o_wake_pin_b    = gif.gated.wake_pin_b;
endmodule

// ===== common/ieg_pkg.sv
// Constants and state types of the interrupt enable gating block
package ieg_pkg;
    // Register bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [7:0] PRIMARY_IRQ_ENABLE_OFS   = 8'ha8;
    localparam logic [7:0] SECONDARY_IRQ_ENABLE_OFS = 8'ha9;
    localparam logic [7:0] PULSE_CH_IRQ_ENABLE_OFS  = 8'hc0;

    // Primary enable register field positions
    localparam int unsigned GLOBAL_IRQ_GATE_BIT      = 7;
    localparam int unsigned TIMER2_IRQ_EN_BIT        = 5;
    localparam int unsigned UART1_IRQ_EN_BIT         = 4;
    localparam int unsigned TIMER1_IRQ_EN_BIT        = 3;
    localparam int unsigned EXT_PIN1_IRQ_WAKE_EN_BIT = 2;
    localparam int unsigned TIMER0_IRQ_EN_BIT        = 1;
    localparam int unsigned EXT_PIN0_IRQ_WAKE_EN_BIT = 0;

    // Secondary enable register field position
    localparam int unsigned PULSE_GROUP_IRQ_EN_BIT = 7;

    // Pulse channel enable register: channel n sits at bit n
    localparam int unsigned PULSE_CH_NUM = 3;

    // Writable bits of each register; bit 6 of the primary one is reserved
    localparam logic [7:0] PRIMARY_WR_MASK   = 8'hbf;
    localparam logic [7:0] SECONDARY_WR_MASK = 8'h80;
    localparam logic [7:0] PULSE_CH_WR_MASK  = 8'h07;

    // Reset values
    localparam logic [7:0] PRIMARY_RST   = 8'h00;
    localparam logic [7:0] SECONDARY_RST = 8'h00;
    localparam logic [7:0] PULSE_CH_RST  = 8'h00;
    localparam logic [7:0] RDATA_RST     = 8'h00;

    // Register file state of the top module
    typedef struct packed {
        logic [7:0] primary;
        logic [7:0] secondary;
        logic [7:0] pulse_ch;
        logic [7:0] rdata;
    } ieg_regs_type;

    // Registered gated outputs of the gate module
    typedef struct packed {
        logic                    timer0_irq;
        logic                    timer1_irq;
        logic                    timer2_irq;
        logic                    uart1_irq;
        logic                    ext_pin_a_irq;
        logic                    ext_pin_b_irq;
        logic [PULSE_CH_NUM-1:0] pulse_ch_irq;
        logic                    pulse_irq;
        logic                    wake_pin_a;
        logic                    wake_pin_b;
    } ieg_gate_type;
endpackage

// ===== common/ieg_gate_if.sv
// Enable bits, raw requests and gated results between register file and gate
interface ieg_gate_if;
    // Enables from the register file
    logic                             global_irq_gate;
    logic                             timer0_irq_en;
    logic                             timer1_irq_en;
    logic                             timer2_irq_en;
    logic                             uart1_irq_en;
    logic                             ext_pin0_irq_wake_en;
    logic                             ext_pin1_irq_wake_en;
    logic                             pulse_group_irq_en;
    logic [ieg_pkg::PULSE_CH_NUM-1:0] pulse_ch_irq_en;
    // Raw requests from the sources
    logic                             timer0_req;
    logic                             timer1_req;
    logic                             timer2_req;
    logic                             uart1_req;
    logic                             ext_irq_pin_a;
    logic                             ext_irq_pin_b;
    logic [ieg_pkg::PULSE_CH_NUM-1:0] pulse_ch_req;
    // Gated results
    ieg_pkg::ieg_gate_type            gated;

    modport regs (
        output global_irq_gate, timer0_irq_en, timer1_irq_en, timer2_irq_en,
        output uart1_irq_en, ext_pin0_irq_wake_en, ext_pin1_irq_wake_en,
        output pulse_group_irq_en, pulse_ch_irq_en,
        output timer0_req, timer1_req, timer2_req, uart1_req,
        output ext_irq_pin_a, ext_irq_pin_b, pulse_ch_req,
        input  gated
    );
    modport gate (
        input  global_irq_gate, timer0_irq_en, timer1_irq_en, timer2_irq_en,
        input  uart1_irq_en, ext_pin0_irq_wake_en, ext_pin1_irq_wake_en,
        input  pulse_group_irq_en, pulse_ch_irq_en,
        input  timer0_req, timer1_req, timer2_req, uart1_req,
        input  ext_irq_pin_a, ext_irq_pin_b, pulse_ch_req,
        output gated
    );
endinterface

// ===== rtl/ieg_gate.sv
// Gating of interrupt requests and wake-up requests by the enable bits
module ieg_gate (
    // Clock, reset and freeze
    input  wire logic i_mclk,
    input  wire logic i_rstn,
    input  wire logic i_ce,
    // Enables in, gated requests out
    ieg_gate_if.gate  gif
);
    ieg_pkg::ieg_gate_type st_reg;   // Registered gated outputs
    ieg_pkg::ieg_gate_type st_next;  // Next value

    // Request passes only with its own enable and the global gate
    function automatic logic gate_req(input logic req, input logic en, input logic glob);
        gate_req = req & en & glob;
    endfunction

    // Combine requests with enables; one cycle of latency to the core
    always_comb begin
        st_next               = st_reg;
        st_next.timer2_irq    = gate_req(gif.timer2_req, gif.timer2_irq_en,
                                         gif.global_irq_gate);
        st_next.uart1_irq     = gate_req(gif.uart1_req, gif.uart1_irq_en,
                                         gif.global_irq_gate);
        st_next.timer1_irq    = gate_req(gif.timer1_req, gif.timer1_irq_en,
                                         gif.global_irq_gate);
        st_next.ext_pin_b_irq = gate_req(gif.ext_irq_pin_b, gif.ext_pin1_irq_wake_en,
                                         gif.global_irq_gate);
        st_next.timer0_irq    = gate_req(gif.timer0_req, gif.timer0_irq_en,
                                         gif.global_irq_gate);
        st_next.ext_pin_a_irq = gate_req(gif.ext_irq_pin_a, gif.ext_pin0_irq_wake_en,
                                         gif.global_irq_gate);
        // Wake-up follows the pin enable alone, so the gate does not keep a sleeper asleep
        st_next.wake_pin_b    = gif.ext_irq_pin_b & gif.ext_pin1_irq_wake_en;
        st_next.wake_pin_a    = gif.ext_irq_pin_a & gif.ext_pin0_irq_wake_en;
        // Pulse channels need channel enable, group enable and global gate
        for (int n = 0; n < int'(ieg_pkg::PULSE_CH_NUM); n++) begin
            st_next.pulse_ch_irq[n] = gate_req(gif.pulse_ch_req[n],
                                               gif.pulse_ch_irq_en[n] & gif.pulse_group_irq_en,
                                               gif.global_irq_gate);
        end
        st_next.pulse_irq     = |st_next.pulse_ch_irq;
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    assign gif.gated = st_reg;
endmodule

// ===== tb/ieg_core_model.sv
// Behavioural model of the core interrupt logic that takes the gated requests
module ieg_core_model (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    // Gated requests in, clear of the record in
    input  wire logic [9:0] i_irq,
    input  wire logic       i_clr,
    // Requests seen since the last clear
    output logic      [9:0] o_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Core samples its request lines every cycle; sticky so a one-cycle glitch is not lost
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_seen <= 10'h000;
        end else if (i_clr) begin
            o_seen <= 10'h000;
        end else begin
            o_seen <= o_seen | i_irq;
        end
    end
endmodule

// ===== tb/ieg_top_sva.sv
// Port-level checks of the interrupt enable gating block
module ieg_top_sva (
    // Clock, reset, freeze and register port
    input wire logic       i_mclk, i_rstn, i_ce, i_wr, i_rd,
    input wire logic [7:0] i_addr, i_wdata, o_rdata,
    // Raw requests, with the gated pulse channels of the same width
    input wire logic       i_timer0_req, i_timer1_req, i_timer2_req, i_uart1_req,
    input wire logic       i_ext_irq_pin_a, i_ext_irq_pin_b,
    input wire logic [2:0] i_pulse_ch_req, o_pulse_ch_irq,
    // Gated requests and wake-ups
    input wire logic       o_timer0_irq, o_timer1_irq, o_timer2_irq, o_uart1_irq,
    input wire logic       o_ext_pin_a_irq, o_ext_pin_b_irq, o_pulse_irq,
    input wire logic       o_wake_pin_a, o_wake_pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] p_reg;  // Shadow of the primary enables
    logic       s_reg;  // Shadow of the group enable
    logic [2:0] c_reg;  // Shadow of the channel enables
    // Shadows rebuilt from the write strobes, so no internal probe is needed
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            p_reg <= 8'h00;
            s_reg <= 1'b0;
            c_reg <= 3'h0;
        end else if (i_ce && i_wr) begin
            if (i_addr == 8'ha8) p_reg <= i_wdata & 8'hbf;
            if (i_addr == 8'ha9) s_reg <= i_wdata[7];
            if (i_addr == 8'hc0) c_reg <= i_wdata[2:0];
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    gate_off_a: assert property (i_ce && !p_reg[7] |=>
        !(o_timer0_irq | o_timer1_irq | o_timer2_irq | o_uart1_irq | o_ext_pin_a_irq
        | o_ext_pin_b_irq | o_pulse_irq)) else $error("irq passed with global gate off");
    timer2_a: assert property (i_ce |=>
        o_timer2_irq == $past(i_timer2_req & p_reg[7] & p_reg[5]))
        else $error("timer2 gating wrong");
    uart1_a: assert property (i_ce |=>
        o_uart1_irq == $past(i_uart1_req & p_reg[7] & p_reg[4]))
        else $error("uart1 gating wrong");
    timer1_a: assert property (i_ce |=>
        o_timer1_irq == $past(i_timer1_req & p_reg[7] & p_reg[3]))
        else $error("timer1 gating wrong");
    pin_b_a: assert property (i_ce |=>
        o_wake_pin_b == $past(i_ext_irq_pin_b & p_reg[2]) &&
        o_ext_pin_b_irq == $past(i_ext_irq_pin_b & p_reg[2] & p_reg[7]))
        else $error("pin b wrong");
    timer0_a: assert property (i_ce |=>
        o_timer0_irq == $past(i_timer0_req & p_reg[7] & p_reg[1]))
        else $error("timer0 gating wrong");
    pin_a_a: assert property (i_ce |=>
        o_wake_pin_a == $past(i_ext_irq_pin_a & p_reg[0]) &&
        o_ext_pin_a_irq == $past(i_ext_irq_pin_a & p_reg[0] & p_reg[7]))
        else $error("pin a wrong");
    pulse_group_a: assert property (i_ce |=> o_pulse_irq == |o_pulse_ch_irq &&
        o_pulse_ch_irq == $past(i_pulse_ch_req & c_reg & {3{s_reg & p_reg[7]}}))
        else $error("pulse gating wrong");
    read_back_a: assert property (i_ce && i_rd && i_addr == 8'ha8 |=>
        o_rdata == $past(p_reg))
        else $error("primary read back wrong");
    read_idle_a: assert property (i_ce && !i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read cycle");
    cover property (i_ce && i_rd && i_addr == 8'ha9);
    cover property (p_reg[7] && o_timer2_irq);
    cover property (o_pulse_irq && o_wake_pin_a);
endmodule

// ===== tb/test_interrupt_enable_gating.sv
// Self-checking bench of the interrupt enable gating block
module test_interrupt_enable_gating;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_mclk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic [8:0] req = 9'h000;  // {pulse[2:0], uart1, timer2, timer1, timer0, pin b, pin a}
    logic [9:0] irq;           // Same order with the pulse OR on top
    logic [1:0] wake;          // {pin b, pin a}
    logic       clr = 1'b0;    // Clears the core model record
    logic [9:0] seen;          // Requests the core model saw
    int         n_errors = 0, total_checks = 0;
    ieg_top i_ieg_top (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_timer0_req(req[2]), .i_timer1_req(req[3]), .i_timer2_req(req[4]),
        .i_uart1_req(req[5]), .i_ext_irq_pin_a(req[0]), .i_ext_irq_pin_b(req[1]),
        .i_pulse_ch_req(req[8:6]), .o_timer0_irq(irq[2]), .o_timer1_irq(irq[3]),
        .o_timer2_irq(irq[4]), .o_uart1_irq(irq[5]), .o_ext_pin_a_irq(irq[0]),
        .o_ext_pin_b_irq(irq[1]), .o_pulse_ch_irq(irq[8:6]), .o_pulse_irq(irq[9]),
        .o_wake_pin_a(wake[0]), .o_wake_pin_b(wake[1]));
    ieg_core_model i_ieg_core_model (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_irq(irq),
        .i_clr(clr), .o_seen(seen));
    // Compare and count
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    // One-cycle read strobe; data stands only in the next cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk("read data", {2'b00, exp}, {2'b00, o_rdata});
    endtask
    // Gated vector worked out from the enable bits, same order as irq
    function automatic logic [9:0] exp_irq(logic [7:0] p, logic s, logic [2:0] c, logic [8:0] r);
        logic [2:0] ch;
        logic [5:0] en;
        ch = r[8:6] & c & {3{p[7] & s}};
        en = {p[4], p[5], p[3], p[1], p[2], p[0]} & {6{p[7]}};
        return {|ch, ch, en & r[5:0]};
    endfunction
    // Write all enables, raise requests, check one cycle later
    task automatic gate(input logic [7:0] p, input logic [7:0] s, input logic [2:0] c,
                        input logic [8:0] r);
        logic [9:0] e;
        e = exp_irq(p, s[7], c, r);
        wr(8'ha8, p);
        wr(8'ha9, s);
        wr(8'hc0, {5'h00, c});
        req <= r;
        @(posedge i_mclk);
        #1 chk("gated irq", e, irq);
        chk("wake", {8'h00, p[2] & r[1], p[0] & r[0]}, {8'h00, wake});
    endtask
    task automatic t_reset_values;
        rd(8'ha8, 8'h00);
        rd(8'ha9, 8'h00);
        rd(8'hc0, 8'h00);
    endtask
    task automatic t_each_source;
        // One source enabled at a time, every request raised
        for (int i = 0; i < 6; i++) begin
            gate(8'h80 | (8'h01 << i), 8'h00, 3'h0, 9'h1ff);
        end
        gate(8'hbf, 8'h00, 3'h0, 9'h000);
    endtask
    task automatic t_global_off;
        gate(8'h3f, 8'h80, 3'h7, 9'h1ff);
        @(posedge i_mclk);
        clr <= 1'b1;
        @(posedge i_mclk);
        clr <= 1'b0;
        repeat (4) @(posedge i_mclk);
        #1 chk("core saw", 10'h000, seen);
    endtask
    task automatic t_pulse;
        gate(8'h80, 8'h00, 3'h5, 9'h1c0);
        gate(8'h80, 8'h80, 3'h5, 9'h1c0);
        gate(8'h80, 8'h80, 3'h2, 9'h140);
        gate(8'h00, 8'h80, 3'h7, 9'h1c0);
    endtask
    // Reserved bits, unmapped write, frozen write
    task automatic t_regs;
        wr(8'ha8, 8'hff);
        wr(8'ha9, 8'hff);
        wr(8'hc0, 8'hff);
        wr(8'h55, 8'h00);
        rd(8'ha8, 8'hbf);
        rd(8'ha9, 8'h80);
        rd(8'hc0, 8'h07);
        rd(8'h55, 8'h00);
        @(posedge i_mclk);
        i_ce <= 1'b0;
        wr(8'ha8, 8'h00);
        i_ce <= 1'b1;
        rd(8'ha8, 8'hbf);
    endtask
    // Reset in mid-run clears every enable again
    task automatic t_mid_reset;
        wr(8'ha8, 8'hff);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rstn <= 1'b1;
        rd(8'ha8, 8'h00);
        rd(8'ha9, 8'h00);
        rd(8'hc0, 8'h00);
        chk("irq after reset", 10'h000, irq);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Clock
    initial begin
        forever #12.5 i_mclk = ~i_mclk;
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge i_mclk);
        i_rstn <= 1'b1;
        t_reset_values();
        t_each_source();
        t_global_off();
        t_pulse();
        t_regs();
        t_mid_reset();
        report_and_stop();
    end
    // Watchdog: the whole run needs about 130 cycles
    initial begin
        repeat (3000) @(posedge i_mclk);
        n_errors++;
        report_and_stop();
    end
endmodule
bind ieg_top ieg_top_sva i_ieg_top_sva (.*);
